/* File: shared/dpt_pkg.sv */
/*
 * Holds the register map, field positions, reset values and the
 * serial-port framing constants shared by the power/transmit-enable control block.
 * Assumes byte-wide registers reached through a 15-bit serial-port address.
 */
package dpt_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [14:0] DPT_ADDR_PWR_DOWN = 15'h0011; // converter_power_down
    localparam logic [14:0] DPT_ADDR_TX_MASK = 15'h0012; // tx_enable_power_mask
    localparam logic [14:0] DPT_ADDR_AMP_SRC = 15'h0013; // amplifier_and_txen_source
    localparam logic [14:0] DPT_ADDR_DELAY = 15'h0014; // output_delay_coarse
    localparam logic [14:0] DPT_ADDR_IRQ_EN = 15'h001F; // interrupt_enable_pll

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DPT_RST_PWR_DOWN = 8'hF8;
    localparam logic [7:0] DPT_RST_TX_MASK = 8'h00;
    localparam logic [7:0] DPT_RST_AMP_SRC = 8'h20;
    localparam logic [7:0] DPT_RST_DELAY = 8'h08;
    localparam logic [7:0] DPT_RST_IRQ_EN = 8'h00;

    // ------------------------------------------------------------
    // Writable-bit masks (reserved read-only bits stay zero)
    // ------------------------------------------------------------
    localparam logic [7:0] DPT_WMASK_PWR_DOWN = 8'hF8;
    localparam logic [7:0] DPT_WMASK_TX_MASK = 8'hFF;
    localparam logic [7:0] DPT_WMASK_AMP_SRC = 8'h7F;
    localparam logic [7:0] DPT_WMASK_DELAY = 8'h0F;
    localparam logic [7:0] DPT_WMASK_IRQ_EN = 8'hFF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DPT_BIT_REF_PD = 7;
    localparam int DPT_BIT_A_I_PD = 6;
    localparam int DPT_BIT_A_Q_PD = 5;
    localparam int DPT_BIT_B_I_PD = 4;
    localparam int DPT_BIT_B_Q_PD = 3;
    localparam int DPT_BIT_B_MASK = 7;
    localparam int DPT_BIT_A_MASK = 6;
    localparam int DPT_BIT_SRC_PROT = 6;
    localparam int DPT_BIT_SRC_TXSM = 5;
    localparam int DPT_BIT_SRC_BLANK = 4;
    localparam int DPT_BIT_SRC_SW = 3;
    localparam int DPT_BIT_SW_ON = 2;
    localparam int DPT_BIT_TXEN_SEL = 1;
    localparam int DPT_BIT_TXEN_LVL = 0;
    localparam int DPT_BIT_CONV_LOST = 5;
    localparam int DPT_BIT_CONV_LOCK = 4;
    localparam int DPT_BIT_LINK_LOST = 3;
    localparam int DPT_BIT_LINK_LOCK = 2;
    localparam int DPT_DELAY_MSB = 3;

    // ------------------------------------------------------------
    // Serial-port framing: 1 direction bit, 15 address bits, 8 data bits
    // ------------------------------------------------------------
    localparam logic [4:0] DPT_SPI_INSTR_LAST = 5'h0F;
    localparam logic [4:0] DPT_SPI_DATA_FIRST = 5'h10;
    localparam logic [4:0] DPT_SPI_FRAME_LAST = 5'h17;
    localparam int DPT_SPI_RW_BIT = 15;

endpackage

/* File: logic/dpt_spi_slave.sv */
/*
 * Serial programming port slave: one 24-bit frame per chip select,
 * direction bit (1 = read), 15-bit address, 8-bit data, MSB first.
 * Assumes the serial clock is far slower than clk_i and synchronous to it.
 */
module dpt_spi_slave
    import dpt_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Serial pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    // Register side
    output logic [14:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_we_o,
    input wire logic [7:0] reg_rdata_i
);

    logic sclk_q; // Previous serial clock level
    logic [4:0] cnt_q; // Bits taken in this frame
    logic [14:0] shift_q; // Incoming bits
    logic rd_q; // Frame is a read
    logic [7:0] out_q; // Outgoing read data
    logic rise, fall, done_q;

    assign rise = ~spi_cs_n_i & spi_sclk_i & ~sclk_q;
    assign fall = ~spi_cs_n_i & ~spi_sclk_i & sclk_q;

    // Edge history of the serial clock
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= spi_sclk_i;
        end
    end

    // Bit counter and input shifter
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || spi_cs_n_i) begin
            cnt_q <= '0;
            shift_q <= '0;
            done_q <= 1'b0;
        end else if (rise && !done_q) begin
            shift_q <= {shift_q[13:0], spi_sdi_i};
            cnt_q <= cnt_q + 5'h1;
            // Extra clocks after a full frame are ignored
            if (cnt_q == DPT_SPI_FRAME_LAST) begin
                done_q <= 1'b1;
            end
        end
    end

    // Latch direction and address at the end of the instruction
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_q <= 1'b0;
            reg_addr_o <= '0;
        end else if (rise && cnt_q == DPT_SPI_INSTR_LAST) begin
            rd_q <= shift_q[DPT_SPI_RW_BIT - 1];
            reg_addr_o <= {shift_q[13:0], spi_sdi_i};
        end
    end

    // Write strobe on the last data bit of a write frame
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_we_o <= 1'b0;
            reg_wdata_o <= '0;
        end else begin
            reg_we_o <= rise && !done_q && !rd_q && cnt_q == DPT_SPI_FRAME_LAST;
            if (rise && cnt_q == DPT_SPI_FRAME_LAST) begin
                reg_wdata_o <= {shift_q[6:0], spi_sdi_i};
            end
        end
    end

    // Read data: loaded on the first falling edge of the data phase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || spi_cs_n_i) begin
            out_q <= '0;
        end else if (fall && cnt_q == DPT_SPI_DATA_FIRST) begin
            out_q <= reg_rdata_i;
        end else if (fall && cnt_q > DPT_SPI_DATA_FIRST) begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    // Drive the data pin only during the data phase of a read
    assign spi_sdo_o = out_q[7];
    assign spi_sdo_oe_o = ~spi_cs_n_i & rd_q & (cnt_q >= DPT_SPI_DATA_FIRST) & ~done_q;

endmodule // dpt_spi_slave

/* File: logic/dpt_ctrl.sv */
/*
 * Power-down and transmit-enable control register group with its
 * serial programming port; drives converter power-downs and amplifier enable.
 * Assumes transmit-enable pins and amplifier sources are synchronous to clk_i.
 */
module dpt_ctrl
    import dpt_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Serial programming port
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    // Transmit-enable pins
    input wire logic transmit_enable_pin_a_i,
    input wire logic transmit_enable_pin_b_i,
    // Amplifier enable sources
    input wire logic amp_protection_error_i,
    input wire logic amp_tx_state_machine_on_i,
    input wire logic amp_blanking_on_i,
    // Power controls
    output logic reference_power_down_o,
    output logic [3:0] converter_power_down_o,
    output logic amp_enable_o,
    // Configuration to neighbouring blocks
    output logic [3:0] coarse_delay_code_o,
    output logic conv_pll_unlock_irq_en_o,
    output logic conv_pll_locked_irq_en_o,
    output logic link_pll_unlock_irq_en_o,
    output logic link_pll_locked_irq_en_o
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] pwr_down_q; // converter_power_down
    logic [7:0] tx_mask_q; // tx_enable_power_mask
    logic [7:0] amp_src_q; // amplifier_and_txen_source
    logic [7:0] delay_q; // output_delay_coarse
    logic [7:0] irq_en_q; // interrupt_enable_pll
    logic [14:0] reg_addr; // Port address
    logic [7:0] reg_wdata; // Port write data
    logic reg_we; // Port write strobe
    logic [7:0] reg_rdata; // Read-back to port
    logic txen_a, txen_b; // Selected transmit-enable levels
    logic [3:0] pd_d; // Next converter power-downs
    logic amp_d; // Next amplifier enable

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    dpt_spi_slave u_spi (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .spi_sclk_i(spi_sclk_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_sdi_i(spi_sdi_i),
        .spi_sdo_o(spi_sdo_o),
        .spi_sdo_oe_o(spi_sdo_oe_o),
        .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata),
        .reg_we_o(reg_we),
        .reg_rdata_i(reg_rdata)
    );

    // Merge write data into writable bits only
    function automatic logic [7:0] dpt_merge(input logic [7:0] wdata, input logic [7:0] wmask);
        dpt_merge = wdata & wmask;
    endfunction

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Power-down register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pwr_down_q <= DPT_RST_PWR_DOWN;
        end else if (reg_we && reg_addr == DPT_ADDR_PWR_DOWN) begin
            pwr_down_q <= dpt_merge(reg_wdata, DPT_WMASK_PWR_DOWN);
        end
    end

    // Mask register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_mask_q <= DPT_RST_TX_MASK;
        end else if (reg_we && reg_addr == DPT_ADDR_TX_MASK) begin
            tx_mask_q <= dpt_merge(reg_wdata, DPT_WMASK_TX_MASK);
        end
    end

    // Amplifier source register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            amp_src_q <= DPT_RST_AMP_SRC;
        end else if (reg_we && reg_addr == DPT_ADDR_AMP_SRC) begin
            amp_src_q <= dpt_merge(reg_wdata, DPT_WMASK_AMP_SRC);
        end
    end

    // Coarse delay register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            delay_q <= DPT_RST_DELAY;
        end else if (reg_we && reg_addr == DPT_ADDR_DELAY) begin
            delay_q <= dpt_merge(reg_wdata, DPT_WMASK_DELAY);
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_en_q <= DPT_RST_IRQ_EN;
        end else if (reg_we && reg_addr == DPT_ADDR_IRQ_EN) begin
            irq_en_q <= dpt_merge(reg_wdata, DPT_WMASK_IRQ_EN);
        end
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            DPT_ADDR_PWR_DOWN: reg_rdata = pwr_down_q;
            DPT_ADDR_TX_MASK: reg_rdata = tx_mask_q;
            DPT_ADDR_AMP_SRC: reg_rdata = amp_src_q;
            DPT_ADDR_DELAY: reg_rdata = delay_q;
            DPT_ADDR_IRQ_EN: reg_rdata = irq_en_q;
            // Unmapped addresses read zero
            default: reg_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Power-down logic
    // ------------------------------------------------------------
    // Software substitute or pins
    assign txen_a = amp_src_q[DPT_BIT_TXEN_SEL] ? amp_src_q[DPT_BIT_TXEN_LVL]
                                                : transmit_enable_pin_a_i;
    assign txen_b = amp_src_q[DPT_BIT_TXEN_SEL] ? amp_src_q[DPT_BIT_TXEN_LVL]
                                                : transmit_enable_pin_b_i;

    // Individual bit OR masked low enable
    always_comb begin
        pd_d[0] = pwr_down_q[DPT_BIT_A_I_PD] | (tx_mask_q[DPT_BIT_A_MASK] & ~txen_a);
        pd_d[1] = pwr_down_q[DPT_BIT_A_Q_PD] | (tx_mask_q[DPT_BIT_A_MASK] & ~txen_a);
        pd_d[2] = pwr_down_q[DPT_BIT_B_I_PD] | (tx_mask_q[DPT_BIT_B_MASK] & ~txen_b);
        pd_d[3] = pwr_down_q[DPT_BIT_B_Q_PD] | (tx_mask_q[DPT_BIT_B_MASK] & ~txen_b);
    end

    // ------------------------------------------------------------
    // Amplifier enable source: software, protection, blanking, tx machine
    // ------------------------------------------------------------
    always_comb begin
        if (amp_src_q[DPT_BIT_SRC_SW]) begin
            amp_d = amp_src_q[DPT_BIT_SW_ON];
        end else if (amp_src_q[DPT_BIT_SRC_PROT]) begin
            amp_d = ~amp_protection_error_i;
        end else if (amp_src_q[DPT_BIT_SRC_BLANK]) begin
            amp_d = amp_blanking_on_i;
        end else if (amp_src_q[DPT_BIT_SRC_TXSM]) begin
            amp_d = amp_tx_state_machine_on_i;
        end else begin
            amp_d = 1'b0;
        end
    end

    // Registered power and amplifier outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reference_power_down_o <= 1'b1;
            converter_power_down_o <= 4'hF;
            amp_enable_o <= 1'b0;
        end else begin
            reference_power_down_o <= pwr_down_q[DPT_BIT_REF_PD];
            converter_power_down_o <= pd_d;
            amp_enable_o <= amp_d;
        end
    end

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    assign coarse_delay_code_o = delay_q[DPT_DELAY_MSB:0];
    assign conv_pll_unlock_irq_en_o = irq_en_q[DPT_BIT_CONV_LOST];
    assign conv_pll_locked_irq_en_o = irq_en_q[DPT_BIT_CONV_LOCK];
    assign link_pll_unlock_irq_en_o = irq_en_q[DPT_BIT_LINK_LOST];
    assign link_pll_locked_irq_en_o = irq_en_q[DPT_BIT_LINK_LOCK];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_REF_PD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_we && reg_addr == DPT_ADDR_PWR_DOWN && reg_wdata[DPT_BIT_REF_PD]
        |=> ##1 reference_power_down_o)
        else $error("Reference not powered down after write");
    AST_A_I_PD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_we && reg_addr == DPT_ADDR_PWR_DOWN && reg_wdata[DPT_BIT_A_I_PD]
        |=> ##1 converter_power_down_o[0])
        else $error("Pair A I not powered down");
    AST_A_Q_EN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_we && reg_addr == DPT_ADDR_PWR_DOWN && !reg_wdata[DPT_BIT_A_Q_PD]
        && !tx_mask_q[DPT_BIT_A_MASK] && $stable(tx_mask_q) |=> ##1 !converter_power_down_o[1])
        else $error("Pair A Q not enabled");
    AST_B_MASK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_mask_q[DPT_BIT_B_MASK] && !txen_b |=> converter_power_down_o[3:2] == 2'b11)
        else $error("Pair B not forced down");
    AST_A_MASK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_mask_q[DPT_BIT_A_MASK] && !txen_a |=> converter_power_down_o[1:0] == 2'b11)
        else $error("Pair A not forced down");
    AST_NO_MASK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !tx_mask_q[DPT_BIT_B_MASK]
        |=> converter_power_down_o[2] == $past(pwr_down_q[DPT_BIT_B_I_PD]))
        else $error("Pair B follows enable without mask");
    AST_SRC_RESET: assert property (@(posedge clk_i)
        $past(!rst_n_i) && rst_n_i |-> amp_src_q == DPT_RST_AMP_SRC)
        else $error("Amplifier source reset wrong");
    AST_SW_AMP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        amp_src_q[DPT_BIT_SRC_SW] |=> amp_enable_o == $past(amp_src_q[DPT_BIT_SW_ON]))
        else $error("Software amplifier control ignored");
    AST_TXEN_SW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        amp_src_q[DPT_BIT_TXEN_SEL] && !amp_src_q[DPT_BIT_TXEN_LVL]
        && tx_mask_q[DPT_BIT_A_MASK] && transmit_enable_pin_a_i |=> converter_power_down_o[0])
        else $error("Software enable level not used");
    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pwr_down_q[2:0] == 3'h0 && amp_src_q[7] == 1'b0 && delay_q[7:4] == 4'h0)
        else $error("Reserved bits read nonzero");

endmodule // dpt_ctrl

/* File: tb/dpt_host.sv */
/*
 * Host processor model: serial programming port master and the two transmit-enable pins.
 * Assumes the bench clock at 20 MHz; every pin changes on its falling edge.
 */
module dpt_host (
    // Clock
    input wire logic clk_i,
    // Serial pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    // Transmit-enable pins
    output logic pin_a_o,
    output logic pin_b_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Sets both transmit-enable pins on a falling edge
    task automatic set_pins(input logic a, input logic b);
        @(negedge clk_i);
        pin_a_o = a;
        pin_b_o = b;
    endtask

    // One 24-bit frame; phases of three cycles keep clear of the two-cycle minimum
    task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                         output logic [7:0] q);
        logic [23:0] f;
        int i;
        f = {rd, addr, wd};
        q = 8'h00;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (i = 23; i >= 0; i--) begin
            sdi_o = f[i];
            repeat (3) @(negedge clk_i);
            // Undriven data line reads unknown, so a missing enable fails
            if (i < 8) begin
                q[i] = sdo_oe_i ? sdo_i : 1'bx;
            end
            sclk_o = 1'b1;
            repeat (3) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        // Let the write land before deselecting
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        // Data line carries junk between frames
        sdi_o = ~sdi_o;
        repeat (3) @(negedge clk_i);
    endtask
endmodule // dpt_host

/* File: tb/tb_dpt_ctrl.sv */
/*
 * Self-checking bench for the power and transmit-enable control group.
 * Assumes the host model in dpt_host and the register map of dpt_pkg.
 */
module tb_dpt_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import dpt_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic err = 1'b0; // Amplifier protection error
    logic txsm = 1'b1; // Tx state machine request
    logic blank = 1'b0; // Blanking request
    wire sclk, cs_n, sdi, sdo, sdo_oe, pin_a, pin_b, ref_pd, amp;
    wire c_lost, c_lock, l_lost, l_lock;
    wire [3:0] conv_pd;
    wire [3:0] dly;
    wire [15:0] st = {2'b00, ref_pd, conv_pd, amp, dly, c_lost, c_lock, l_lost, l_lock};
    int fails = 0;
    int total_checks = 0;
    logic [15:0] exp_q[$]; // Expected results, oldest first
    logic [15:0] obs; // Result handed to the watcher
    event got;
    logic [14:0] ad[6] = '{15'h0011, 15'h0012, 15'h0013, 15'h0014, 15'h001F, 15'h0015};
    logic [7:0] rv[6] = '{8'hF8, 8'h00, 8'h20, 8'h08, 8'h00, 8'h00}; // Reset values
    logic [7:0] wm[6] = '{8'hF8, 8'hFF, 8'h7F, 8'h0F, 8'hFF, 8'h00}; // Writable bits

    // ------------------------------------------------------------
    // Clock, instances
    // ------------------------------------------------------------
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    dpt_host host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe), .pin_a_o(pin_a), .pin_b_o(pin_b));

    dpt_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
        .transmit_enable_pin_a_i(pin_a), .transmit_enable_pin_b_i(pin_b),
        .amp_protection_error_i(err), .amp_tx_state_machine_on_i(txsm),
        .amp_blanking_on_i(blank), .reference_power_down_o(ref_pd),
        .converter_power_down_o(conv_pd), .amp_enable_o(amp), .coarse_delay_code_o(dly),
        .conv_pll_unlock_irq_en_o(c_lost), .conv_pll_locked_irq_en_o(c_lock),
        .link_pll_unlock_irq_en_o(l_lost), .link_pll_locked_irq_en_o(l_lock));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Driver notes the expectation and hands over the result
    task automatic see(input logic [15:0] v, input logic [15:0] e);
        exp_q.push_back(e);
        obs = v;
        ->got;
        #1;
    endtask

    // Watcher pairs each result with the oldest note
    initial begin
        forever begin
            @(got);
            chk(obs, exp_q.pop_front());
        end
    end

    // Hang guard
    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        close_out();
    end

    // Expected output word from register contents and input levels
    function automatic logic [15:0] model(logic [7:0] p, logic [7:0] m, logic [7:0] s,
        logic [7:0] d, logic [7:0] ir, logic pa, logic pb, logic e, logic t, logic b);
        logic ta, tb, a;
        logic [3:0] pd;
        ta = s[1] ? s[0] : pa;
        tb = s[1] ? s[0] : pb;
        pd = {p[3] | (m[7] & ~tb), p[4] | (m[7] & ~tb), p[5] | (m[6] & ~ta), p[6] | (m[6] & ~ta)};
        a = s[3] ? s[2] : s[6] ? ~e : s[4] ? b : s[5] ? t : 1'b0;
        return {2'b00, p[7], pd, a, d[3:0], ir[5:2]};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] q, p, m, s, d, ir;
        logic ra, rb;
        void'($urandom(32'h0000_c4ca));
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        see(st, {2'b00, 1'b1, 4'hF, 1'b1, 4'h8, 4'h0});
        // Reset values, unmapped place reads zero
        for (int k = 0; k < 6; k++) begin
            host.frame(1'b1, ad[k], 8'h00, q);
            see({8'h00, q}, {8'h00, rv[k]});
        end
        // All ones: reserved read-only bits stay zero
        for (int k = 0; k < 6; k++) begin
            host.frame(1'b0, ad[k], 8'hFF, q);
            host.frame(1'b1, ad[k], 8'h00, q);
            see({8'h00, q}, {8'h00, wm[k]});
        end
        // Random register contents against random pin and source levels
        for (int n = 0; n < 12; n++) begin
            p = 8'($urandom);
            m = 8'($urandom);
            s = 8'($urandom);
            d = 8'($urandom);
            ir = 8'($urandom);
            ra = 1'($urandom);
            rb = 1'($urandom);
            host.frame(1'b0, DPT_ADDR_PWR_DOWN, p, q);
            host.frame(1'b0, DPT_ADDR_TX_MASK, m, q);
            host.frame(1'b0, DPT_ADDR_AMP_SRC, s, q);
            host.frame(1'b0, DPT_ADDR_DELAY, d, q);
            host.frame(1'b0, DPT_ADDR_IRQ_EN, ir, q);
            host.set_pins(ra, rb);
            err = 1'($urandom);
            txsm = 1'($urandom);
            blank = 1'($urandom);
            repeat (2) @(negedge clk_i);
            see(st, model(p, m, s, d, ir, ra, rb, err, txsm, blank));
            host.frame(1'b1, DPT_ADDR_AMP_SRC, 8'h00, q);
            see({8'h00, q}, {8'h00, 1'b0, s[6:0]});
        end
        close_out();
    end
endmodule // tb_dpt_ctrl
